// ==== acm_pkg.sv ====
/*
 Package for the access control entry flag and EtherType matcher.
 Assumes a 32-bit APB slave on a single 10 MHz clock.
*/
package acm_pkg;
    localparam int ACM_ADDR_W = 12;
    localparam int ACM_DATA_W = 32;
    localparam int ACM_FLAG_N = 6;
    localparam int ACM_ETYPE_W = 16;

    // Byte offsets
    localparam logic [11:0] ACM_OFF_CTRL = 12'h000;
    localparam logic [11:0] ACM_OFF_FLAGS = 12'h004;
    localparam logic [11:0] ACM_OFF_ETYPE = 12'h008;
    localparam logic [11:0] ACM_OFF_STATUS = 12'h00C;
    localparam logic [11:0] ACM_OFF_HITCNT = 12'h010;

    // Flag index within a TCP flag vector
    localparam int ACM_FIN = 0;
    localparam int ACM_SYN = 1;
    localparam int ACM_RST = 2;
    localparam int ACM_PSH = 3;
    localparam int ACM_ACK = 4;
    localparam int ACM_URG = 5;

    // Control register fields
    localparam int ACM_CTRL_ENTRY_EN = 0;
    localparam int ACM_CTRL_ETYPE_FT = 1;
    localparam int ACM_CTRL_ETYPE_SPEC = 2;

    // Status register fields
    localparam int ACM_ST_HIT = 0;
    localparam int ACM_ST_VALID = 1;
    localparam int ACM_ST_BADCFG = 2;

    localparam logic [15:0] ACM_ETYPE_MIN = 16'h0600;
    localparam logic [15:0] ACM_ETYPE_IPV4 = 16'h0800;
    localparam logic [15:0] ACM_ETYPE_ARP = 16'h0806;
    localparam logic [15:0] ACM_ETYPE_IPV6 = 16'h86DD;
    localparam logic [15:0] ACM_ETYPE_RST = 16'h0600;
    localparam logic [11:0] ACM_FLAGS_RST = 12'hFFF;

    // Two-bit per-flag criterion
    typedef enum logic [1:0] {
        ACM_CRIT_ZERO = 2'b00,
        ACM_CRIT_ONE = 2'b01,
        ACM_CRIT_ANY = 2'b11
    } acm_crit_t;
endpackage

// ==== acm_cfg_if.sv ====
/*
 Interface carrying the entry's flag and EtherType settings, but not its enable, from the register file to the matcher.
 Assumes both ends share clock_in.
*/
`timescale 1ns/1ps
interface acm_cfg_if;
    logic [11:0] flag_crit;
    logic etype_ft;
    logic etype_spec;
    logic [15:0] etype_val;
    modport src (output flag_crit, etype_ft, etype_spec, etype_val);
    modport dst (input flag_crit, etype_ft, etype_spec, etype_val);
endinterface

// ==== acm_match.sv ====
/*
 Combinational matcher of one access control entry against parsed header fields.
 Assumes fields are stable in the cycle that frame_valid is high.
*/
`timescale 1ns/1ps
module acm_match (
    acm_cfg_if.dst cfg,
    input wire logic is_tcp_in,
    input wire logic [5:0] tcp_flags_in,
    input wire logic [15:0] etype_in,
    output logic hit_out
);
    import acm_pkg::*;

    logic [ACM_FLAG_N-1:0] flag_ok;
    logic etype_ok;

    function automatic logic flag_pass(input logic [1:0] crit, input logic flag);
        flag_pass = 1'b1;
        if (crit == ACM_CRIT_ZERO && flag) begin
            flag_pass = 1'b0;
        end else if (crit == ACM_CRIT_ONE && !flag) begin
            flag_pass = 1'b0;
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < ACM_FLAG_N; gi++) begin : g_flag
            // Non-TCP frames are untouched by flag criteria
            assign flag_ok[gi] = !is_tcp_in ||
                flag_pass(cfg.flag_crit[2*gi +: 2], tcp_flags_in[gi]); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07
        end
    endgenerate

    always_comb begin
        etype_ok = 1'b1;
        if (cfg.etype_ft && cfg.etype_spec) begin // RULE_08 RULE_09
            etype_ok = (etype_in == cfg.etype_val); // RULE_10
        end
    end

    assign hit_out = (&flag_ok) && etype_ok; // RULE_12
endmodule

// ==== acm_top.sv ====
/*
 APB-configured single access control entry matcher for TCP flags and EtherType.
 Assumes the frame parser presents one frame per frame_valid pulse.
*/
// The register addresses and the APB slave port were decided locally.
// Overview of operation
// (RULE_01) FIN criterion one or any allows matching
// (RULE_02) FIN criterion zero blocks FIN frames
// (RULE_03) SYN criterion zero, one or any
// (RULE_04) RST criterion zero, one or any
// (RULE_05) PSH criterion zero, one or any
// (RULE_06) ACK criterion zero, one or any
// (RULE_07) URG criterion zero, one or any
// (RULE_08) EtherType check only for Ethernet Type entries
// (RULE_09) EtherType any imposes no constraint
// (RULE_10) Specific EtherType must equal configured value
// (RULE_11) Software avoids IPv4, ARP, IPv6 EtherTypes
// (RULE_12) Hit needs every criterion satisfied together
`timescale 1ns/1ps
module acm_top (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [acm_pkg::ACM_ADDR_W-1:0] paddr_in,
    input wire logic [acm_pkg::ACM_DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [acm_pkg::ACM_DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic frame_valid_in,
    input wire logic is_tcp_in,
    input wire logic [5:0] tcp_flags_in,
    input wire logic [acm_pkg::ACM_ETYPE_W-1:0] etype_in,
    output logic result_valid_out,
    output logic entry_hit_out
);
    import acm_pkg::*;

    acm_cfg_if cfg ();

    logic entry_en_ff;
    logic etype_ft_ff;
    logic etype_spec_ff;
    logic [11:0] flag_crit_ff;
    logic [15:0] etype_val_ff;
    logic result_valid_ff;
    logic entry_hit_ff;
    logic [31:0] hit_cnt_ff;
    logic [31:0] prdata_ff;
    logic raw_hit;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic bad_cfg;
    logic sel_ctrl;
    logic sel_flags;
    logic sel_etype;
    logic sel_status;
    logic sel_hitcnt;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_etype;
    logic wr_hitcnt;
    logic hit_event;
    logic [31:0] flags_merged;
    logic [31:0] etype_merged;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == ACM_OFF_CTRL) || (a == ACM_OFF_FLAGS) ||
                     (a == ACM_OFF_ETYPE) || (a == ACM_OFF_STATUS) ||
                     (a == ACM_OFF_HITCNT);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    assign addr_ok = addr_known(paddr_in);
    assign wr_en = psel_in && penable_in && pwrite_in && addr_ok;
    assign rd_en = psel_in && !penable_in && !pwrite_in;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;
    assign prdata_out = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register selects and write strobes

    assign sel_ctrl = (paddr_in == ACM_OFF_CTRL);
    assign sel_flags = (paddr_in == ACM_OFF_FLAGS);
    assign sel_etype = (paddr_in == ACM_OFF_ETYPE);
    assign sel_status = (paddr_in == ACM_OFF_STATUS);
    assign sel_hitcnt = (paddr_in == ACM_OFF_HITCNT);

    assign wr_ctrl = wr_en && sel_ctrl;
    assign wr_flags = wr_en && sel_flags;
    assign wr_etype = wr_en && sel_etype;
    assign wr_hitcnt = wr_en && sel_hitcnt;

    // Byte-lane merge of the current value with the write data
    assign flags_merged = merge({20'h0_0000, flag_crit_ff}, pwdata_in, pstrb_in);
    assign etype_merged = merge({16'h0000, etype_val_ff}, pwdata_in, pstrb_in);

    // Software must avoid reserved EtherTypes; flagged here for visibility
    assign bad_cfg = etype_spec_ff && ((etype_val_ff == ACM_ETYPE_IPV4) ||
                     (etype_val_ff == ACM_ETYPE_ARP) || (etype_val_ff == ACM_ETYPE_IPV6) ||
                     (etype_val_ff < ACM_ETYPE_MIN)); // RULE_11

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            entry_en_ff <= 1'b0;
            etype_ft_ff <= 1'b0;
            etype_spec_ff <= 1'b0;
        end else if (wr_ctrl && pstrb_in[0]) begin
            entry_en_ff <= pwdata_in[ACM_CTRL_ENTRY_EN];
            etype_ft_ff <= pwdata_in[ACM_CTRL_ETYPE_FT];
            etype_spec_ff <= pwdata_in[ACM_CTRL_ETYPE_SPEC];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flag_crit_ff <= ACM_FLAGS_RST;
        end else if (wr_flags) begin
            flag_crit_ff <= flags_merged[11:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            etype_val_ff <= ACM_ETYPE_RST;
        end else if (wr_etype) begin
            etype_val_ff <= etype_merged[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in setup phase

    always_comb begin
        rd_word = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_word[ACM_CTRL_ENTRY_EN] = entry_en_ff;
            rd_word[ACM_CTRL_ETYPE_FT] = etype_ft_ff;
            rd_word[ACM_CTRL_ETYPE_SPEC] = etype_spec_ff;
        end
        if (sel_flags) begin
            rd_word[11:0] = flag_crit_ff;
        end
        if (sel_etype) begin
            rd_word[15:0] = etype_val_ff;
        end
        if (sel_status) begin
            rd_word[ACM_ST_HIT] = entry_hit_ff;
            rd_word[ACM_ST_VALID] = result_valid_ff;
            rd_word[ACM_ST_BADCFG] = bad_cfg;
        end
        if (sel_hitcnt) begin
            rd_word = hit_cnt_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_ff <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Matcher

    assign cfg.flag_crit = flag_crit_ff;
    assign cfg.etype_ft = etype_ft_ff;
    assign cfg.etype_spec = etype_spec_ff;
    assign cfg.etype_val = etype_val_ff;

    acm_match u_match (
        .cfg(cfg),
        .is_tcp_in(is_tcp_in),
        .tcp_flags_in(tcp_flags_in),
        .etype_in(etype_in),
        .hit_out(raw_hit)
    );

    // Reported and counted hits share one term
    assign hit_event = frame_valid_in && entry_en_ff && raw_hit; // RULE_12

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            result_valid_ff <= 1'b0;
            entry_hit_ff <= 1'b0;
        end else begin
            result_valid_ff <= frame_valid_in;
            if (frame_valid_in) begin
                entry_hit_ff <= hit_event; // RULE_12
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hit_cnt_ff <= 32'h0000_0000;
        end else if (wr_hitcnt) begin
            hit_cnt_ff <= 32'h0000_0000;
        end else if (hit_event) begin
            hit_cnt_ff <= hit_cnt_ff + 32'h0000_0001;
        end
    end

    assign result_valid_out = result_valid_ff;
    assign entry_hit_out = entry_hit_ff;
endmodule

// ==== acm_top_asserts.sv ====
/*
 Checker for the entry matcher, bound to acm_top.
 Assumes full-word APB writes to keep its shadow settings.
*/
`timescale 1ns/1ps
module acm_top_asserts
    import acm_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ACM_ADDR_W-1:0] paddr_in,
    input wire logic [ACM_DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [ACM_DATA_W-1:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic frame_valid_in,
    input wire logic is_tcp_in,
    input wire logic [5:0] tcp_flags_in,
    input wire logic [ACM_ETYPE_W-1:0] etype_in,
    input wire logic result_valid_out,
    input wire logic entry_hit_out
);
    logic [2:0] ctl_ff;
    logic [11:0] crit_ff;
    logic [15:0] et_ff;
    logic [5:0] zm;
    logic [5:0] om;
    logic bad;
    logic etx;
    // Shadow of the entry settings
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctl_ff <= 3'h0;
            crit_ff <= ACM_FLAGS_RST;
            et_ff <= ACM_ETYPE_RST;
        end else if (psel_in && penable_in && pwrite_in && pstrb_in == 4'hF) begin
            if (paddr_in == ACM_OFF_CTRL) ctl_ff <= pwdata_in[2:0];
            if (paddr_in == ACM_OFF_FLAGS) crit_ff <= pwdata_in[11:0];
            if (paddr_in == ACM_OFF_ETYPE) et_ff <= pwdata_in[15:0];
        end
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            zm[i] = crit_ff[2*i+:2] == 2'b00;
            om[i] = crit_ff[2*i+:2] == 2'b01;
        end
    end
    assign bad = is_tcp_in && |((zm & tcp_flags_in) | (om & ~tcp_flags_in));
    assign etx = ctl_ff[1] && ctl_ff[2] && etype_in != et_ff;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    AST_RESULT_PULSE: assert property (frame_valid_in |=> result_valid_out)
        else $error("no result after frame");
    AST_NO_SPURIOUS: assert property (!frame_valid_in |=> !result_valid_out)
        else $error("result without frame");
    AST_HIT_HOLD: assert property (!result_valid_out |-> $stable(entry_hit_out))
        else $error("hit changed without result");
    AST_FLAG_ZERO: assert property (frame_valid_in && is_tcp_in && |(zm & tcp_flags_in)
        |=> !entry_hit_out)
        else $error("hit despite flag set under zero");
    AST_FLAG_ONE: assert property (frame_valid_in && is_tcp_in && |(om & ~tcp_flags_in)
        |=> !entry_hit_out)
        else $error("hit despite flag clear under one");
    AST_ETYPE_DIFF: assert property (frame_valid_in && etx |=> !entry_hit_out)
        else $error("hit despite EtherType mismatch");
    AST_DISABLED: assert property (frame_valid_in && !ctl_ff[0] |=> !entry_hit_out)
        else $error("hit on disabled entry");
    AST_ALL_MET: assert property (frame_valid_in && ctl_ff[0] && !bad && !etx
        |=> entry_hit_out)
        else $error("miss with every criterion met");
    AST_NO_WAIT: assert property (psel_in |-> pready_out)
        else $error("pready low in transfer");
endmodule
bind acm_top acm_top_asserts i_acm_top_asserts(.clock_in(clock_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .frame_valid_in(frame_valid_in),
    .is_tcp_in(is_tcp_in), .tcp_flags_in(tcp_flags_in), .etype_in(etype_in),
    .result_valid_out(result_valid_out), .entry_hit_out(entry_hit_out));

// ==== acm_parser_model.sv ====
/*
 Frame parser model presenting one parsed frame per call.
 Assumes the caller waits for the returned edge before the next call.
*/
`timescale 1ns/1ps
module acm_parser_model (
    input wire logic clock_in,
    output logic frame_valid_out,
    output logic is_tcp_out,
    output logic [5:0] flags_out,
    output logic [15:0] etype_out
);
    initial begin
        frame_valid_out = 1'b0;
        is_tcp_out = 1'b0;
        flags_out = 6'h00;
        etype_out = 16'h0000;
    end
    // Fields go stale outside the valid cycle
    task automatic send(input logic t, input logic [5:0] f, input logic [15:0] e);
        @(posedge clock_in);
        frame_valid_out <= 1'b1;
        is_tcp_out <= t;
        flags_out <= f;
        etype_out <= e;
        @(posedge clock_in);
        frame_valid_out <= 1'b0;
        is_tcp_out <= ~t;
        flags_out <= ~f;
        etype_out <= ~e;
    endtask
endmodule

// ==== acm_top_tb.sv ====
/*
 Testbench for acm_top: APB set-up, then frames with expected hits.
 Assumes the parser model and the bound checker.
*/
`timescale 1ns/1ps
module acm_top_tb;
    import acm_pkg::*;
    logic clock_in, rst_in, psel, penable, pwrite, pready, pslverr;
    logic fv, tcp, rv, hit, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [5:0] fl;
    logic [15:0] et;
    logic [1:0] c;
    int miscompares, compares;
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    acm_top i_acm_top(.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .frame_valid_in(fv), .is_tcp_in(tcp), .tcp_flags_in(fl), .etype_in(et),
        .result_valid_out(rv), .entry_hit_out(hit));
    acm_parser_model i_acm_parser_model(.clock_in(clock_in), .frame_valid_out(fv),
        .is_tcp_out(tcp), .flags_out(fl), .etype_out(et));
    ////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop;
        end
    endtask
    task automatic frm(input logic t, input logic [5:0] f, input logic [15:0] v, input logic x);
        i_acm_parser_model.send(t, f, v);
        #1;
        chk("result_valid", 32'h0000_0001, {31'h0, rv});
        chk("entry_hit", {31'h0, x}, {31'h0, hit});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_in = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        pstrb = 4'hF;
        miscompares = 0;
        compares = 0;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        apb(0, ACM_OFF_FLAGS, 0);
        chk("flags_reset", 32'h0000_0FFF, q);
        apb(0, ACM_OFF_ETYPE, 0);
        chk("etype_reset", 32'h0000_0600, q);
        apb(0, 12'h040, 0);
        chk("unmapped_err", 32'h0000_0001, {31'h0, e});
        chk("unmapped_data", 32'h0000_0000, q);
        frm(1, 6'h3F, 16'h0600, 0);
        apb(1, ACM_OFF_CTRL, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 3; k++) begin
                for (int s = 0; s < 2; s++) begin
                    c = (k == 2) ? 2'b11 : k[1:0];
                    apb(1, ACM_OFF_FLAGS, (32'hFFF & ~(32'h3 << 2*i)) | (c << 2*i));
                    frm(1, s ? 6'h3F : ~(6'h01 << i), 16'h1234,
                        c == 2'b00 ? !s : (c == 2'b01 ? s : 1));
                end
            end
        end
        apb(1, ACM_OFF_FLAGS, 32'h0000_0000);
        frm(0, 6'h3F, 16'h1234, 1);
        apb(1, ACM_OFF_FLAGS, 32'h0000_0FFF);
        apb(1, ACM_OFF_ETYPE, 32'h0000_0600);
        apb(1, ACM_OFF_CTRL, 32'h0000_0007);
        frm(1, 6'h00, 16'h0600, 1);
        frm(1, 6'h00, 16'h0601, 0);
        apb(1, ACM_OFF_ETYPE, 32'h0000_FFFF);
        frm(1, 6'h00, 16'hFFFF, 1);
        frm(1, 6'h00, 16'hFFFE, 0);
        apb(1, ACM_OFF_CTRL, 32'h0000_0003);
        frm(1, 6'h00, 16'h0601, 1);
        apb(1, ACM_OFF_CTRL, 32'h0000_0005);
        frm(1, 6'h00, 16'h0601, 1);
        apb(1, ACM_OFF_CTRL, 32'h0000_0007);
        apb(1, ACM_OFF_FLAGS, 32'h0000_0FFC);
        frm(1, 6'h01, 16'hFFFF, 0);
        frm(1, 6'h02, 16'hFFFF, 1);
        apb(0, ACM_OFF_STATUS, 0);
        chk("status", 32'h0000_0001, q);
        apb(0, ACM_OFF_CTRL, 0);
        chk("ctrl_readback", 32'h0000_0007, q);
        apb(0, ACM_OFF_HITCNT, 0);
        chk("hit_count", 32'h0000_001E, q);
        apb(1, ACM_OFF_HITCNT, 0);
        apb(0, ACM_OFF_HITCNT, 0);
        chk("hit_count_clr", 32'h0000_0000, q);
        report_and_stop;
    end
endmodule
